// ---- src/asa_pkg.sv ----
// shared constants for the slot arbiter and address decoder
// assumes one bus clock; register map reached over apb
package asa_pkg;
	// ==========================================
	// sizes and slot entry fields
	localparam int ASA_NM     = 7;
	localparam int ASA_NSLOT  = 16;
	localparam int ASA_NREG   = 4;
	localparam int ASA_NCS    = 8;
	localparam int ASA_NSLV   = 19;
	localparam int ASA_EN_BIT = 7;
	localparam int ASA_BW_LSB = 4;
	localparam int ASA_OWN_LSB = 0;
	localparam logic [1:0] ASA_BW_FULL = 2'h0;
	localparam logic [1:0] ASA_BW_75   = 2'h1;
	localparam logic [1:0] ASA_BW_50   = 2'h2;
	localparam logic [1:0] ASA_BW_25   = 2'h3;
	// ==========================================
	// current-master codes
	localparam logic [3:0] ASA_M_CPU    = 4'h0;
	localparam logic [3:0] ASA_M_ERX    = 4'h1;
	localparam logic [3:0] ASA_M_ETX    = 4'h2;
	localparam logic [3:0] ASA_M_RSVD   = 4'h3;
	localparam logic [3:0] ASA_M_PCI    = 4'h4;
	localparam logic [3:0] ASA_M_PERIPH = 4'h5;
	localparam logic [3:0] ASA_M_LCD    = 4'h6;
	// ==========================================
	// register offsets and reset values
	localparam logic [7:0]  ASA_OFS_SLOT0  = 8'h00;
	localparam logic [7:0]  ASA_OFS_CS0    = 8'h10;
	localparam logic [7:0]  ASA_OFS_STATUS = 8'h50;
	localparam logic [31:0] ASA_SLOT0_RST  = 32'h8000_0000;
	localparam logic [31:0] ASA_SLOT_RST   = 32'h0000_0000;
	localparam logic [31:0] ASA_DYN_BASE   = 32'h0000_0000;
	localparam logic [31:0] ASA_STA_BASE   = 32'h4000_0000;
	localparam logic [31:0] ASA_CS_SPAN    = 32'h1000_0000;
	localparam logic [31:0] ASA_CS_MASK_RST = 32'hf000_0000;
	localparam int ASA_ST_MASTER_LSB = 0;
	localparam int ASA_ST_GRANT_LSB  = 8;
	localparam int ASA_ST_REQ_LSB    = 16;
	// ==========================================
	// fixed address map
	localparam logic [3:0] ASA_NIB_PCIMEM = 4'h8;
	localparam logic [3:0] ASA_NIB_PERIPH = 4'h9;
	localparam logic [3:0] ASA_NIB_IOWIN  = 4'ha;
	localparam logic [7:0] ASA_WIN_PCIIO  = 8'h00;
	localparam logic [7:0] ASA_WIN_CFGA   = 8'h01;
	localparam logic [7:0] ASA_WIN_CFGD   = 8'h02;
	localparam logic [7:0] ASA_WIN_PARB   = 8'h03;
	localparam logic [7:0] ASA_WIN_BRIDGE = 8'h04;
	localparam logic [7:0] ASA_WIN_ETH    = 8'h06;
	localparam logic [7:0] ASA_WIN_MEMC   = 8'h07;
	localparam logic [7:0] ASA_WIN_LCD    = 8'h08;
	localparam logic [7:0] ASA_WIN_SYSC   = 8'h09;
	localparam int ASA_S_PCIMEM = 8;
	localparam int ASA_S_PERIPH = 9;
	localparam int ASA_S_PCIIO  = 10;
	localparam int ASA_S_CFGA   = 11;
	localparam int ASA_S_CFGD   = 12;
	localparam int ASA_S_PARB   = 13;
	localparam int ASA_S_BRIDGE = 14;
	localparam int ASA_S_ETH    = 15;
	localparam int ASA_S_MEMC   = 16;
	localparam int ASA_S_LCD    = 17;
	localparam int ASA_S_SYSC   = 18;
	// ==========================================
	// ahb codes and default slave states
	localparam logic [1:0] ASA_HTRANS_IDLE = 2'h0;
	localparam logic [1:0] ASA_HRESP_ERROR = 2'h1;
	localparam logic [1:0] ASA_HRESP_OKAY  = 2'h0;
	localparam logic [1:0] ASA_HRESP_SPLIT = 2'h3;
	localparam int ASA_HPROT_PRIV = 1;
	typedef enum logic [2:0] {
		ASA_DS_IDLE = 3'b001,
		ASA_DS_ERR1 = 3'b010,
		ASA_DS_ERR2 = 3'b100
	} asa_ds_t;

	function automatic logic [31:0] asa_cs_base_rst(input int i);
		if (i < 4)
			return ASA_STA_BASE + ASA_CS_SPAN * 32'(i);
		return ASA_DYN_BASE + ASA_CS_SPAN * 32'(i - 4);
	endfunction
endpackage

// ---- src/asa_addr_decode.sv ----
// combinational address decoder: at most one select per address
// assumes chip-select base/mask come from registers in the parent
`timescale 1ns/1ns
`default_nettype none
module asa_addr_decode
	import asa_pkg::*;
(
	input  wire logic [31:0]                haddr,
	input  wire logic [ASA_NCS-1:0][31:0]   cs_base,
	input  wire logic [ASA_NCS-1:0][31:0]   cs_mask,
	output logic      [ASA_NSLV-1:0]        sel,
	output logic                            internal,
	output logic                            reserved
);
	logic [ASA_NCS-1:0] cs_hit;

	// ==========================================
	// relocatable chip selects
	genvar g;
	generate
		for (g = 0; g < ASA_NCS; g++)
		begin : gen_cs
			assign cs_hit[g] = ((haddr ^ cs_base[g]) & cs_mask[g]) == 32'h0;
		end
	endgenerate

	// ==========================================
	// map
	always_comb
	begin
		sel = '0;
		internal = 1'b0;
		reserved = 1'b0;
		// chip selects live only below the fixed map; relocating one higher is ignored
		if (haddr[31:28] < ASA_NIB_PCIMEM)
		begin
			reserved = ~|cs_hit;
			for (int i = ASA_NCS - 1; i >= 0; i--)
				if (cs_hit[i])
				begin
					sel = '0;
					sel[i] = 1'b1;
				end
		end
		else
		begin
			case (haddr[31:28])
				ASA_NIB_PCIMEM: sel[ASA_S_PCIMEM] = 1'b1;
				ASA_NIB_PERIPH: sel[ASA_S_PERIPH] = 1'b1;
				ASA_NIB_IOWIN:
				begin
					internal = 1'b1;
					case (haddr[27:20])
						ASA_WIN_PCIIO:
						begin
							sel[ASA_S_PCIIO] = 1'b1;
							internal = 1'b0;
						end
						ASA_WIN_CFGA:   sel[ASA_S_CFGA] = 1'b1;
						ASA_WIN_CFGD:   sel[ASA_S_CFGD] = 1'b1;
						ASA_WIN_PARB:   sel[ASA_S_PARB] = 1'b1;
						ASA_WIN_BRIDGE: sel[ASA_S_BRIDGE] = 1'b1;
						ASA_WIN_ETH:    sel[ASA_S_ETH] = 1'b1;
						ASA_WIN_MEMC:   sel[ASA_S_MEMC] = 1'b1;
						ASA_WIN_LCD:    sel[ASA_S_LCD] = 1'b1;
						ASA_WIN_SYSC:   sel[ASA_S_SYSC] = 1'b1;
						default:
						begin
							internal = 1'b0;
							reserved = 1'b1;
						end
					endcase
				end
				default: reserved = 1'b1;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- src/asa_slot_arbiter.sv ----
// slot arbiter, registered slave selects, default error slave, apb regs
// assumes ahb masters request on hbusreq indexed by master code
`timescale 1ns/1ns
`default_nettype none
module asa_slot_arbiter
	import asa_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	input  wire logic                  clk_en,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata_q,
	output logic                       pready_q,
	output logic                       pslverr_q,
	input  wire logic [ASA_NM-1:0]     hbusreq,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic [3:0]            hprot,
	input  wire logic                  hready,
	input  wire logic [1:0]            hresp,
	output logic      [ASA_NM-1:0]     hgrant_q,
	output logic      [3:0]            hmaster_q,
	output logic      [ASA_NSLV-1:0]   hsel_q,
	output logic                       hready_dflt_q,
	output logic      [1:0]            hresp_dflt_q
);
	logic [ASA_NREG-1:0][31:0] slot_q, slot_d;
	logic [ASA_NCS-1:0][31:0]  csb_q, csb_d, csm_q, csm_d;
	logic [31:0]               prdata_d;
	logic                      pready_d, pslverr_d;
	logic [ASA_NSLOT-1:0]      slot_req, slot_en, slot_q25;
	logic [ASA_NSLOT-1:0][3:0] slot_own;
	logic [3:0]                last_q, last_d, pick;
	logic [1:0]                phase_q, phase_d;
	logic [ASA_NM-1:0]         hgrant_d;
	logic [3:0]                hmaster_d;
	logic                      found, rearb;
	logic [ASA_NSLV-1:0]       dec_sel, hsel_d;
	logic                      dec_int, dec_rsv, bad_xfer;
	asa_ds_t                   ds_q, ds_d;
	logic                      hready_dflt_d;
	logic [1:0]                hresp_dflt_d;

	// ==========================================
	// apb register file
	logic [5:0] idx;
	logic       is_slot, is_cs, is_st, map_ok;
	logic [2:0] cs_n;
	logic [31:0] rd;

	always_comb
	begin
		idx = paddr[7:2];
		is_slot = idx < 6'(ASA_NREG);
		is_cs = idx >= ASA_OFS_CS0[7:2] && idx < ASA_OFS_CS0[7:2] + 6'(2 * ASA_NCS);
		is_st = idx == ASA_OFS_STATUS[7:2];
		cs_n = 3'((idx - ASA_OFS_CS0[7:2]) >> 1);
		map_ok = is_slot || is_cs || (is_st && !pwrite);
		rd = 32'h0;
		if (is_slot)
			rd = slot_q[idx[1:0]];
		else if (is_cs)
			rd = idx[0] ? csm_q[cs_n] : csb_q[cs_n];
		else if (is_st)
		begin
			rd[ASA_ST_MASTER_LSB +: 4] = hmaster_q;
			rd[ASA_ST_GRANT_LSB +: ASA_NM] = hgrant_q;
			rd[ASA_ST_REQ_LSB +: ASA_NSLOT] = slot_req;
		end
		slot_d = slot_q;
		csb_d = csb_q;
		csm_d = csm_q;
		// one wait state: ready rises in the second access cycle
		pready_d = psel && penable && !pready_q;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		if (pready_d)
		begin
			prdata_d = pwrite ? 32'h0 : rd;
			pslverr_d = !map_ok;
		end
		if (psel && penable && pready_q && pwrite && map_ok)
		begin
			if (is_slot)
				slot_d[idx[1:0]] = pwdata;
			else if (idx[0])
				csm_d[cs_n] = pwdata;
			else
				csb_d[cs_n] = pwdata;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// only slot 0 on, cpu, full rate
			slot_q <= {ASA_SLOT_RST, ASA_SLOT_RST, ASA_SLOT_RST, ASA_SLOT0_RST};
			for (int i = 0; i < ASA_NCS; i++)
			begin
				csb_q[i] <= asa_cs_base_rst(i);
				csm_q[i] <= ASA_CS_MASK_RST;
			end
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (clk_en)
		begin
			slot_q <= slot_d;
			csb_q <= csb_d;
			csm_q <= csm_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ==========================================
	// slot requests
	genvar g;
	generate
		for (g = 0; g < ASA_NSLOT; g++)
		begin : gen_slot
			logic [7:0] ent;
			logic [1:0] bw;
			logic       bw_ok;
			// slot 0 is bits 31:24 of the first register
			assign ent = slot_q[g / 4][8 * (3 - g % 4) +: 8];
			assign bw = ent[ASA_BW_LSB +: 2];
			assign bw_ok = (bw == ASA_BW_FULL) || (bw == ASA_BW_75 && phase_q != 2'h3) ||
				(bw == ASA_BW_50 && !phase_q[0]) || (bw == ASA_BW_25 && phase_q == 2'h0);
			assign slot_en[g] = ent[ASA_EN_BIT];
			// owner code selects the request line
			assign slot_own[g] = ent[ASA_OWN_LSB +: 4];
			assign slot_q25[g] = bw == ASA_BW_25;
			// only enabled slots of requesting owners
			assign slot_req[g] = slot_en[g] && bw_ok && slot_own[g] < 4'(ASA_NM) &&
				hbusreq[slot_own[g][2:0]];
		end
	endgenerate

	// ==========================================
	// round robin arbiter
	logic [3:0] cand;

	always_comb
	begin
		pick = last_q;
		found = 1'b0;
		cand = last_q;
		// search from the slot after the last winner
		for (int k = 1; k <= ASA_NSLOT; k++)
		begin
			cand = last_q + 4'(k);
			if (!found && slot_req[cand])
			begin
				pick = cand;
				found = 1'b1;
			end
		end
		// idle, new transaction address, owner done, or split
		rearb = (hready && (htrans[0] == 1'b0 || !hbusreq[hmaster_q[2:0]])) ||
			hresp == ASA_HRESP_SPLIT;
		hgrant_d = hgrant_q;
		hmaster_d = hmaster_q;
		last_d = last_q;
		phase_d = rearb ? phase_q + 2'h1 : phase_q;
		// unused slots fall through to the next requester
		if (rearb && found)
		begin
			hgrant_d = '0;
			hgrant_d[slot_own[pick][2:0]] = 1'b1;
			// code driven is the owner code
			hmaster_d = slot_own[pick];
			last_d = pick;
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hgrant_q <= ASA_NM'(1) << ASA_M_CPU;
			hmaster_q <= ASA_M_CPU;
			last_q <= 4'h0;
			phase_q <= 2'h0;
		end
		else if (clk_en)
		begin
			hgrant_q <= hgrant_d;
			hmaster_q <= hmaster_d;
			last_q <= last_d;
			phase_q <= phase_d;
		end
	end

	// ==========================================
	// decoder and default slave
	asa_addr_decode u_dec (
		.haddr    (haddr),
		.cs_base  (csb_q),
		.cs_mask  (csm_q),
		.sel      (dec_sel),
		.internal (dec_int),
		.reserved (dec_rsv)
	);

	always_comb
	begin
		bad_xfer = hready && htrans[1] && (dec_rsv || (dec_int && !hprot[ASA_HPROT_PRIV]));
		hsel_d = hsel_q;
		// selects are registered, so they mark the data phase
		if (hready)
			hsel_d = (htrans[1] && !bad_xfer) ? dec_sel : '0;
		ds_d = ds_q;
		case (ds_q)
			ASA_DS_IDLE: if (bad_xfer) ds_d = ASA_DS_ERR1;
			ASA_DS_ERR1: ds_d = ASA_DS_ERR2;
			ASA_DS_ERR2: ds_d = bad_xfer ? ASA_DS_ERR1 : ASA_DS_IDLE;
			default:     ds_d = ASA_DS_IDLE;
		endcase
		hready_dflt_d = ds_d != ASA_DS_ERR1;
		hresp_dflt_d = (ds_d == ASA_DS_IDLE) ? ASA_HRESP_OKAY : ASA_HRESP_ERROR;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hsel_q <= '0;
			ds_q <= ASA_DS_IDLE;
			hready_dflt_q <= 1'b1;
			hresp_dflt_q <= ASA_HRESP_OKAY;
		end
		else if (clk_en)
		begin
			hsel_q <= hsel_d;
			ds_q <= ds_d;
			hready_dflt_q <= hready_dflt_d;
			hresp_dflt_q <= hresp_dflt_d;
		end
	end

	// ==========================================
	// checks
	// single grant
	grant_onehot_a: assert property (
		@(posedge mclk) disable iff (!rst_n) $onehot(hgrant_q))
		else $error("grant not one-hot");
	slot_disabled_a: assert property (
		@(posedge mclk) disable iff (!rst_n) rearb && found |-> slot_en[pick])
		else $error("disabled slot won arbitration");
	bw_quarter_a: assert property (
		@(posedge mclk) disable iff (!rst_n) rearb && found && slot_q25[pick] |-> phase_q == 2'h0)
		else $error("quarter slot won off phase");
	grant_owner_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clk_en && rearb && found |=> hmaster_q == $past(slot_own[pick]) && hgrant_q[hmaster_q[2:0]])
		else $error("master code not slot owner");
	sel_onehot_a: assert property (
		@(posedge mclk) disable iff (!rst_n) $onehot0(hsel_q) && !(hsel_q != '0 && ds_q == ASA_DS_ERR1))
		else $error("select not unique");
	reserved_err_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clk_en && hready && htrans[1] && haddr[31:28] > ASA_NIB_IOWIN
		|=> !hready_dflt_q && hresp_dflt_q == ASA_HRESP_ERROR && hsel_q == '0)
		else $error("reserved address not refused");
	priv_err_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clk_en && hready && htrans[1] && dec_int && !hprot[ASA_HPROT_PRIV]
		|=> ds_q == ASA_DS_ERR1 && hresp_dflt_q == ASA_HRESP_ERROR)
		else $error("unprivileged access accepted");
	slot_write_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clk_en && psel && penable && pready_q && pwrite && paddr == ASA_OFS_SLOT0
		|=> slot_q[0] == $past(pwdata))
		else $error("slot register write lost");
	// apb wait state
	apb_ready_a: assert property (
		@(posedge mclk) disable iff (!rst_n)
		clk_en && psel && penable && !pready_q |=> pready_q ##1 !pready_q || !clk_en)
		else $error("apb ready timing wrong");
endmodule
`default_nettype wire

// ---- verif/asa_ahb_model.sv ----
// ahb side stand-in: masters that request and issue single transfers
// assumes the dut default slave answers bad transfers; other slaves say okay
`timescale 1ns/1ns
`default_nettype none
module asa_ahb_model
	import asa_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic [ASA_NM-1:0]   req,
	input  wire logic                go,
	input  wire logic [31:0]         go_addr,
	input  wire logic                go_priv,
	input  wire logic                slow,
	input  wire logic                hready_dflt_q,
	input  wire logic [1:0]          hresp_dflt_q,
	output logic      [ASA_NM-1:0]   hbusreq,
	output logic      [31:0]         haddr,
	output logic      [1:0]          htrans,
	output logic      [3:0]          hprot,
	output logic                     hready,
	output logic      [1:0]          hresp
);
	logic stall_q;
	// a slow slave adds one wait state to the data phase
	assign hready = hready_dflt_q & ~stall_q;
	assign hresp = hresp_dflt_q;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hbusreq <= '0;
			haddr <= '0;
			htrans <= ASA_HTRANS_IDLE;
			hprot <= 4'h0;
			stall_q <= 1'b0;
		end
		else
		begin
			hbusreq <= req;
			stall_q <= slow & ~stall_q & htrans[1] & hready;
			if (go)
			begin
				htrans <= 2'h2;
				haddr <= go_addr;
				// privileged bit follows go_priv, whatever the address
				hprot <= {2'h0, go_priv, 1'b1};
			end
			else if (htrans[1] && hready)
			begin
				// address released: show a changed value, not the old one
				htrans <= ASA_HTRANS_IDLE;
				haddr <= ~haddr;
				hprot <= ~hprot;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/asa_slot_arbiter_tb_top.sv ----
// self-checking bench for the slot arbiter and decoder
// assumes the ahb stand-in model beside the dut, apb master tasks here
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module asa_slot_arbiter_tb_top
	import asa_pkg::*;
;
	logic mclk, rst_n, psel, penable, pwrite, pready_q, pslverr_q, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_q, rd, haddr, go_addr;
	logic [ASA_NM-1:0] req, hbusreq, hgrant_q;
	logic go, go_priv, slow, hready, hready_dflt_q, clk_en;
	logic [1:0] htrans, hresp, hresp_dflt_q;
	logic [3:0] hprot, hmaster_q;
	logic [ASA_NSLV-1:0] hsel_q;
	int err_total, checks;
	// {privileged, select index + 1 (0 = error), address}
	logic [39:0] dt [20] = '{{8'h85, 32'h0}, {8'h88, 32'h3fff_fffc}, {8'h81, 32'h4000_0000},
		{8'h84, 32'h7fff_fffc}, {8'h89, 32'h8000_0000}, {8'h8a, 32'h9fff_fffc},
		{8'h8b, 32'ha000_0000}, {8'h8c, 32'ha010_0000}, {8'h8d, 32'ha020_0000},
		{8'h8e, 32'ha030_0000}, {8'h8f, 32'ha040_0000}, {8'h80, 32'ha050_0000},
		{8'h90, 32'ha060_0000}, {8'h91, 32'ha070_0000}, {8'h92, 32'ha080_0000},
		{8'h93, 32'ha090_0000}, {8'h80, 32'ha0a0_0000}, {8'h80, 32'hffff_fffc},
		{8'h00, 32'ha090_0000}, {8'h09, 32'h8000_0000}};

	asa_slot_arbiter u_dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
		.hbusreq(hbusreq), .haddr(haddr), .htrans(htrans), .hprot(hprot),
		.hready(hready), .hresp(hresp), .hgrant_q(hgrant_q), .hmaster_q(hmaster_q),
		.hsel_q(hsel_q), .hready_dflt_q(hready_dflt_q), .hresp_dflt_q(hresp_dflt_q));
	asa_ahb_model u_model (.mclk(mclk), .rst_n(rst_n), .req(req), .go(go),
		.go_addr(go_addr), .go_priv(go_priv), .slow(slow), .hready_dflt_q(hready_dflt_q),
		.hresp_dflt_q(hresp_dflt_q), .hbusreq(hbusreq), .haddr(haddr), .htrans(htrans),
		.hprot(hprot), .hready(hready), .hresp(hresp));

	// ==========================================
	// bus tasks
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		// ready, data and error are taken at the rising edge that completes the access
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready_q !== 1'b1 && n < 50);
		if (pready_q !== 1'b1)
			err_total++;
		rd = prdata_q;
		er = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("rdata", e, rd)
	endtask
	task automatic xfer(input logic [31:0] a, input logic pv, input int idx);
		int n;
		@(posedge mclk);
		go <= 1'b1;
		go_addr <= a;
		go_priv <= pv;
		@(posedge mclk);
		go <= 1'b0;
		n = 0;
		do begin @(negedge mclk); n++; end while (!(htrans[1] && hready) && n < 50);
		if (!(htrans[1] && hready))
			err_total++;
		@(posedge mclk);
		#1;
		if (idx < 0)
		begin
			`CHK("err1", 3'b001, {hready_dflt_q, hresp_dflt_q})
			@(posedge mclk);
			#1;
			`CHK("err2", 3'b101, {hready_dflt_q, hresp_dflt_q})
		end
		else
			`CHK("hsel", 19'h1 << idx, hsel_q)
	endtask

	// ==========================================
	// scenarios
	task automatic t_regs();
		rd_chk(ASA_OFS_SLOT0, 32'h8000_0000);
		for (int r = 1; r < 4; r++)
			rd_chk(8'(4 * r), 32'h0);
		for (int n = 0; n < 8; n++)
		begin
			rd_chk(8'(16 + 8 * n), 32'(n % 4) * 32'h1000_0000 + ((n < 4) ? 32'h4000_0000 : 0));
			rd_chk(8'(20 + 8 * n), 32'hf000_0000);
		end
		rd_chk(ASA_OFS_STATUS, 32'h0000_0100);
		apb(1'b1, ASA_OFS_STATUS, 32'hffff_ffff);
		`CHK("ro", 1'b1, er)
		apb(1'b0, 8'h54, 32'h0);
		`CHK("unmapped", 33'h1_0000_0000, {er, rd})
		for (int r = 0; r < 4; r++)
		begin
			apb(1'b1, 8'(4 * r), 32'h8531_2602 ^ 32'(r));
			rd_chk(8'(4 * r), 32'h8531_2602 ^ 32'(r));
		end
	endtask
	task automatic t_arb();
		logic [3:0] m;
		// slot 1 belongs to eth rx but stays disabled
		apb(1'b1, 8'h00, 32'h8001_0000);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h0);
		apb(1'b1, 8'h0c, 32'h0);
		req <= 7'h02;
		repeat (6) @(posedge mclk);
		`CHK("off", 4'h0, hmaster_q)
		foreach (dt[i])
		begin
			if (i > 6 || i == 3)
				continue;
			m = 4'(i);
			apb(1'b1, 8'h00, {8'h80, 4'h8, m, 16'h0});
			// same owner in two evenly spaced slots
			apb(1'b1, 8'h08, {8'h00, 4'h8, m, 16'h0});
			req <= 7'h1 << m;
			repeat (5) @(posedge mclk);
			#1;
			`CHK("hmaster", m, hmaster_q)
			`CHK("hgrant", 7'h1 << m, hgrant_q)
		end
	endtask
	task automatic t_bw();
		int cnt;
		apb(1'b1, 8'h08, 32'h0);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, 8'h00, {8'h80, 2'h2, 2'(c), 4'h1, 16'h0});
			req <= 7'h03;
			repeat (8) @(posedge mclk);
			cnt = 0;
			repeat (16) begin @(posedge mclk); #1; cnt += int'(hmaster_q === 4'h1); end
			`CHK("share", (c == 3) ? 4 : 8, cnt)
		end
	endtask
	task automatic t_dec();
		foreach (dt[i])
		begin
			@(posedge mclk);
			slow <= i[0];
			xfer(dt[i][31:0], dt[i][39], int'(dt[i][38:32]) - 1);
		end
		apb(1'b1, ASA_OFS_CS0, 32'h2000_0000);
		xfer(32'h2000_0000, 1'b1, 0);
		xfer(32'h4000_0000, 1'b1, -1);
	endtask
	task automatic t_frz();
		apb(1'b1, ASA_OFS_SLOT0, 32'h8081_0000);
		req <= 7'h01;
		repeat (4) @(posedge mclk);
		// state must hold while the enable is low, whatever the requests do
		clk_en <= 1'b0;
		req <= 7'h02;
		repeat (4) @(posedge mclk);
		#1;
		`CHK("frozen", 4'h0, hmaster_q)
		@(posedge mclk);
		clk_en <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		`CHK("thawed", 4'h1, hmaster_q)
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd_chk(ASA_OFS_SLOT0, 32'h8000_0000);
		rd_chk(ASA_OFS_STATUS, 32'h0000_0100);
		rd_chk(ASA_OFS_CS0, 32'h4000_0000);
	endtask

	// ==========================================
	// run control
	task automatic test_done();
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial
	begin
		#(100 * 8000);
		err_total++;
		test_done();
	end
	initial
	begin
		{rst_n, psel, penable, pwrite, paddr, pwdata, req, go, go_addr, go_priv, slow} = '0;
		clk_en = 1'b1;
		err_total = 0;
		checks = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_arb();
		t_bw();
		t_dec();
		t_frz();
		test_done();
	end
endmodule
`default_nettype wire
